// [include/srm_pkg.sv]
// Shared constants, encodings and helpers for the drive timing block.
// Functional notes
// - PWM period is core clock over PWM rate minus one
// - Compare value zero to P sets duty 0..100%
// - PWM runs at 20 kHz, period 999
// - All three timers count up continuously, wrapping
// - Timers: PWM base, capture base, periodic tick
// - PWM mode; high-side outputs 1,3,5 active high
// - Each output polarity chosen by action control
// - Only tick period match raises group B interrupt
// - Five-slice schedule: commutation slice zero, velocity one
// - Three capture events raise group C interrupt
// - Capture: identify unit, store stamp, set flags
// - One capture edge per 7.5 shaft degrees
// - New capture notifies position estimation next tick
// - Four capture pins, four port B outputs
// - Watchdog off; PLL doubles 10 MHz crystal
// - Initial rotor state read from sensor levels
// - Current loop gain constant 22 in Q3
// - Captures use timer two, both edges
// - Capture timer counts at 1.25 MHz
package srm_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int CRYSTAL_HZ = 10_000_000;
  localparam int PLL_MULT = 2;
  localparam int CORE_HZ = CRYSTAL_HZ * PLL_MULT;
  localparam int CORE_DIV = CLK_HZ / CORE_HZ;
  localparam int TIMER_W = 16;
  localparam int PWM_HZ = 20_000;
  localparam int PWM_PERIOD_VAL = CORE_HZ / PWM_HZ - 1;
  localparam int TICK_PERIOD_US = 200;
  localparam int TICK_PERIOD_VAL = CORE_HZ / 1_000_000 * TICK_PERIOD_US - 1;
  localparam int CAP_TIMER_HZ = 1_250_000;
  localparam int CAP_PRESCALE = CORE_HZ / CAP_TIMER_HZ;
  localparam logic [TIMER_W-1:0] PWM_PERIOD_RST = TIMER_W'(PWM_PERIOD_VAL);
  localparam logic [TIMER_W-1:0] TICK_PERIOD_RST = TIMER_W'(TICK_PERIOD_VAL);
  localparam logic [TIMER_W-1:0] CAP_PERIOD = 16'hffff;
  localparam int PHASES = 3;
  localparam int CAP_UNITS = 4;
  localparam int CAP_EDGE_DEG_X10 = 75;
  localparam int SLICES = 5;
  localparam logic [2:0] COMMUTE_SLICE = 3'h0;
  localparam logic [2:0] VELOCITY_SLICE = 3'h1;
  localparam logic [2:0] LAST_SLICE = 3'(SLICES - 1);
  localparam logic [11:0] ACTION_RST = 12'h222;
  localparam logic [3:0] CAP_EN_RST = 4'h7;
  localparam logic [3:0] PORT_B_RST = 4'h0;
  localparam logic [7:0] LOOP_GAIN_Q3 = 8'h16;
  localparam logic [1:0] INIT_SETTLE = 2'h3;
  localparam logic [2:0] CFG_PWM_PERIOD = 3'h0;
  localparam logic [2:0] CFG_TICK_PERIOD = 3'h1;
  localparam logic [2:0] CFG_CMP0 = 3'h2;
  localparam logic [2:0] CFG_ACTION = 3'h5;
  localparam logic [2:0] CFG_PORT_B = 3'h6;
  localparam logic [2:0] CFG_CAP_EN = 3'h7;

  typedef enum logic [1:0] {
    SRM_ACT_FORCE_LO = 2'h0,
    SRM_ACT_LOW = 2'h1,
    SRM_ACT_HIGH = 2'h2,
    SRM_ACT_FORCE_HI = 2'h3
  } srm_action_t;

  // Maps the raw compare result onto the pin level for one output.
  function automatic logic srm_apply_action(input logic raw, input logic [1:0] act);
    unique case (srm_action_t'(act))
      SRM_ACT_FORCE_LO: srm_apply_action = 1'b0;
      SRM_ACT_LOW: srm_apply_action = ~raw;
      SRM_ACT_HIGH: srm_apply_action = raw;
      SRM_ACT_FORCE_HI: srm_apply_action = 1'b1;
    endcase
  endfunction
endpackage

// [include/srm_tb_if.sv]
// Time base bundle passed from a timer to the logic that uses its count.
`timescale 1ns/1ns
interface srm_tb_if #(parameter int W = 16);
  logic [W-1:0] count;
  logic [W-1:0] period;
  logic wrap;
  modport timer (output count, output period, output wrap);
  modport user (input count, input period, input wrap);
endinterface

// [logic/srm_up_timer.sv]
// Continuous up-counting timer that wraps to zero after its period value.
`timescale 1ns/1ns
module srm_up_timer
  import srm_pkg::*;
#(
  parameter int W = TIMER_W
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic step,
  input wire logic [W-1:0] period,
  srm_tb_if.timer tb
);
  logic [W-1:0] count_reg;

  if (W < 2) begin : g_chk
    $error("srm_up_timer: width too small");
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_reg <= '0;
    end else if (step) begin
      // A period lowered below the count wraps to zero on the next step.
      count_reg <= (count_reg >= period) ? '0 : count_reg + 1'b1;
    end
  end

  assign tb.count = count_reg;
  assign tb.period = period;
  assign tb.wrap = step && (count_reg >= period);
endmodule

// [logic/srm_pwm_phase.sv]
// One phase of PWM: shadowed compare and a high-side/low-side output pair.
`timescale 1ns/1ns
module srm_pwm_phase
  import srm_pkg::*;
#(
  parameter int W = TIMER_W
) (
  input wire logic clk,
  input wire logic sys_rst,
  srm_tb_if.user tb,
  input wire logic [W-1:0] cmp,
  input wire logic [1:0] act_hs,
  input wire logic [1:0] act_ls,
  output logic hs_gate,
  output logic ls_gate
);
  logic [W-1:0] active_cmp_reg;
  logic raw;

  // The working compare changes only on the wrap, so a pulse is never cut short.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      active_cmp_reg <= '0;
    end else if (tb.wrap) begin
      active_cmp_reg <= cmp;
    end
  end

  // Compare at or above the period gives a full high period.
  assign raw = (active_cmp_reg >= tb.period) || (tb.count < active_cmp_reg);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hs_gate <= 1'b0;
      ls_gate <= 1'b0;
    end else begin
      hs_gate <= srm_apply_action(raw, act_hs);
      ls_gate <= srm_apply_action(raw, act_ls);
    end
  end
endmodule

// [logic/srm_pwm_tick_scheduler.sv]
// Drive timing block: PWM time base, capture stamping and the tick schedule.
`timescale 1ns/1ns
module srm_pwm_tick_scheduler
  import srm_pkg::*;
#(
  parameter int TW = TIMER_W
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cfg_wr_en,
  input wire logic [2:0] cfg_sel,
  input wire logic [TW-1:0] cfg_wdata,
  input wire logic [CAP_UNITS-1:0] capture_input_pins,
  input wire logic [2:0] sensor_levels,
  input wire logic tick_irq_clear,
  input wire logic [CAP_UNITS-1:0] capture_irq_clear,
  input wire logic velocity_done,
  output logic [2*PHASES-1:0] pwm_gate,
  output logic [3:0] port_b_output_pins,
  output logic [3:0] port_b_oe,
  output logic cpu_irq_group_b,
  output logic cpu_irq_group_c,
  output logic tick_timer_period_irq,
  output logic [CAP_UNITS-1:0] capture_event_irqs,
  output logic [CAP_UNITS*TW-1:0] capture_stamp,
  output logic [1:0] last_capture_unit,
  output logic velocity_request,
  output logic position_new_meas,
  output logic [2:0] slice_index,
  output logic run_current_ctrl,
  output logic run_position_est,
  output logic run_commutation,
  output logic run_velocity_ctrl,
  output logic [2:0] init_sensor_state,
  output logic init_state_valid,
  output logic [TW-1:0] pwm_count,
  output logic [TW-1:0] capture_count,
  output logic [7:0] current_loop_gain_const,
  output logic watchdog_enable
);
  localparam int DIV_W = $clog2(CORE_DIV);
  localparam int PRE_W = $clog2(CAP_PRESCALE);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CORE_DIV - 1);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(CAP_PRESCALE - 1);

  if (TW < 12) begin : g_chk_w
    $error("srm_pwm_tick_scheduler: timer width cannot hold the default periods");
  end
  if (CORE_DIV < 2 || CLK_HZ % CORE_HZ != 0) begin : g_chk_div
    $error("srm_pwm_tick_scheduler: system clock is not a multiple of the core rate");
  end
  // Unit numbers are two bits wide and every action field must fit one write word.
  if (CAP_UNITS > 4 || 4 * PHASES > TW) begin : g_chk_fit
    $error("srm_pwm_tick_scheduler: capture units or phases exceed the ports");
  end
  // A prescale that does not divide the core rate would make the stamps drift.
  if (CAP_PRESCALE < 2 || CORE_HZ % CAP_TIMER_HZ != 0) begin : g_chk_pre
    $error("srm_pwm_tick_scheduler: capture rate is not a divisor of the core rate");
  end
  // The run strobes assume commutation in slice zero and velocity in a later slice.
  if (SLICES > 8 || COMMUTE_SLICE != 3'h0 || VELOCITY_SLICE == 3'h0) begin : g_chk_slice
    $error("srm_pwm_tick_scheduler: slice schedule does not fit the slice counter");
  end

  // Configuration and state registers.
  logic [DIV_W-1:0] core_div_reg;
  logic core_tick;
  logic [PRE_W-1:0] cap_pre_reg;
  logic cap_step;
  logic [TW-1:0] pwm_timer_period_reg;
  logic [TW-1:0] tick_period_reg;
  logic [TW-1:0] phase_compare_reg [PHASES];
  logic [2*2*PHASES-1:0] output_action_ctrl;
  logic [3:0] port_b_reg;
  logic [CAP_UNITS-1:0] cap_enable_reg;
  logic [CAP_UNITS-1:0] cap_edge;
  logic cap_any;
  logic [1:0] cap_unit_next;
  logic [2:0] slice_reg;
  logic position_pending_reg;
  logic [2:0] sensor_s1_reg;
  logic [2:0] sensor_s2_reg;
  logic [1:0] init_cnt_reg;

  srm_tb_if #(.W(TW)) pwm_tb ();
  srm_tb_if #(.W(TW)) cap_tb ();
  srm_tb_if #(.W(TW)) tick_tb ();

  // Clamp to the live period so a large loop output cannot exceed full duty.
  function automatic logic [TW-1:0] clamp_duty(input logic [TW-1:0] v,
                                               input logic [TW-1:0] p);
    clamp_duty = (v > p) ? p : v;
  endfunction

  // Write decode shared by every per-phase compare register.
  function automatic logic cfg_hit(input logic en, input logic [2:0] s,
                                   input logic [2:0] code);
    cfg_hit = en && (s == code);
  endfunction

  // Core-rate strobe standing in for the crystal times PLL clock.
  // The PWM and tick timers step on this strobe and the capture timer on every 16th, so all three stay in step with one another.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      core_div_reg <= '0;
    end else begin
      core_div_reg <= (core_div_reg == DIV_LAST) ? '0 : core_div_reg + 1'b1;
    end
  end
  assign core_tick = (core_div_reg == DIV_LAST);

  // Capture time base prescaler; coarse steps keep the stamp from overflowing.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cap_pre_reg <= '0;
    end else if (core_tick) begin
      cap_pre_reg <= (cap_pre_reg == PRE_LAST) ? '0 : cap_pre_reg + 1'b1;
    end
  end
  assign cap_step = core_tick && (cap_pre_reg == PRE_LAST);

  // Configuration writes.
  // Period writes act on the live timer; a period below the count wraps on the next step.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pwm_timer_period_reg <= PWM_PERIOD_RST;
      tick_period_reg <= TICK_PERIOD_RST;
      output_action_ctrl <= ACTION_RST;
      port_b_reg <= PORT_B_RST;
      cap_enable_reg <= CAP_EN_RST;
    end else if (cfg_wr_en) begin
      unique case (cfg_sel)
        CFG_PWM_PERIOD: pwm_timer_period_reg <= cfg_wdata;
        CFG_TICK_PERIOD: tick_period_reg <= cfg_wdata;
        CFG_ACTION: output_action_ctrl <= cfg_wdata[2*2*PHASES-1:0];
        CFG_PORT_B: port_b_reg <= cfg_wdata[3:0];
        CFG_CAP_EN: cap_enable_reg <= cfg_wdata[CAP_UNITS-1:0];
        default: ;
      endcase
    end
  end

  // Compare registers, one per phase, each clamped as it is written.
  for (genvar p = 0; p < PHASES; p++) begin : g_cmp
    localparam logic [2:0] SEL = CFG_CMP0 + 3'(p);
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        phase_compare_reg[p] <= '0;
      end else if (cfg_hit(cfg_wr_en, cfg_sel, SEL)) begin
        phase_compare_reg[p] <= clamp_duty(cfg_wdata, pwm_timer_period_reg);
      end
    end
  end

  // The three time bases.
  srm_up_timer #(.W(TW)) u_pwm_timer (
    .clk(clk),
    .sys_rst(sys_rst),
    .step(core_tick),
    .period(pwm_timer_period_reg),
    .tb(pwm_tb.timer)
  );

  srm_up_timer #(.W(TW)) u_cap_timer (
    .clk(clk),
    .sys_rst(sys_rst),
    .step(cap_step),
    .period(CAP_PERIOD),
    .tb(cap_tb.timer)
  );

  srm_up_timer #(.W(TW)) u_tick_timer (
    .clk(clk),
    .sys_rst(sys_rst),
    .step(core_tick),
    .period(tick_period_reg),
    .tb(tick_tb.timer)
  );

  // PWM phases: output 2p is the high-side switch, 2p+1 the low-side.
  for (genvar p = 0; p < PHASES; p++) begin : g_phase
    srm_pwm_phase #(.W(TW)) u_phase (
      .clk(clk),
      .sys_rst(sys_rst),
      .tb(pwm_tb.user),
      .cmp(phase_compare_reg[p]),
      .act_hs(output_action_ctrl[4*p+1:4*p]),
      .act_ls(output_action_ctrl[4*p+3:4*p+2]),
      .hs_gate(pwm_gate[2*p]),
      .ls_gate(pwm_gate[2*p+1])
    );
  end

  // Capture units: synchronise each pin, stamp the capture time on either edge.
  for (genvar u = 0; u < CAP_UNITS; u++) begin : g_cap
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        s1_reg <= 1'b0;
        s2_reg <= 1'b0;
        s3_reg <= 1'b0;
      end else begin
        s1_reg <= capture_input_pins[u];
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
      end
    end
    // Only the edge detector reads the third flop; the first feeds the second alone.
    // Each sensor transition is one 7.5 degree step of the shaft.
    assign cap_edge[u] = (s2_reg ^ s3_reg) && cap_enable_reg[u];

    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        capture_stamp[u*TW +: TW] <= '0;
      end else if (cap_edge[u]) begin
        capture_stamp[u*TW +: TW] <= cap_tb.count;
      end
    end

    // A new edge in the clearing cycle keeps the flag set.
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        capture_event_irqs[u] <= 1'b0;
      end else begin
        capture_event_irqs[u] <= cap_edge[u] || (capture_event_irqs[u] && !capture_irq_clear[u]);
      end
    end
  end

  assign cap_any = |cap_edge;

  // Lowest-numbered unit wins when two edges land in the same cycle.
  always_comb begin
    cap_unit_next = last_capture_unit;
    for (int i = CAP_UNITS - 1; i >= 0; i--) begin
      if (cap_edge[i]) begin
        cap_unit_next = 2'(i);
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      last_capture_unit <= 2'h0;
    end else begin
      last_capture_unit <= cap_unit_next;
    end
  end

  // Velocity request stands until the background work reports done.
  // Background work may run long; the request is sticky so a slow loop still sees it.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      velocity_request <= 1'b0;
    end else begin
      velocity_request <= cap_any || (velocity_request && !velocity_done);
    end
  end

  // Position notice is held until the next tick consumes it.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      position_pending_reg <= 1'b0;
      position_new_meas <= 1'b0;
    end else begin
      position_pending_reg <= cap_any || (position_pending_reg && !tick_tb.wrap);
      position_new_meas <= tick_tb.wrap && position_pending_reg;
    end
  end

  // Tick interrupt from the third timer's period match only.
  // A clear and a new tick in one cycle leave the flag set, so no tick is lost.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tick_timer_period_irq <= 1'b0;
    end else begin
      tick_timer_period_irq <= tick_tb.wrap || (tick_timer_period_irq && !tick_irq_clear);
    end
  end

  assign cpu_irq_group_b = tick_timer_period_irq;
  assign cpu_irq_group_c = |(capture_event_irqs & cap_enable_reg);

  // Five-slice schedule advanced on each tick.
  // It starts on the last slice so the first tick enters slice zero and commutates.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      slice_reg <= LAST_SLICE;
    end else if (tick_tb.wrap) begin
      slice_reg <= (slice_reg == LAST_SLICE) ? 3'h0 : slice_reg + 3'h1;
    end
  end

  // Run strobes are one cycle wide and follow the tick by one cycle.
  // They key on the slice being left, since the slice moves on the same edge.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      run_current_ctrl <= 1'b0;
      run_position_est <= 1'b0;
      run_commutation <= 1'b0;
      run_velocity_ctrl <= 1'b0;
    end else begin
      run_current_ctrl <= tick_tb.wrap;
      run_position_est <= tick_tb.wrap;
      run_commutation <= tick_tb.wrap && (slice_reg == LAST_SLICE);
      run_velocity_ctrl <= tick_tb.wrap && (slice_reg == VELOCITY_SLICE - 3'h1);
    end
  end
  assign slice_index = slice_reg;

  // Sensor levels pass a synchroniser; the state is caught once after reset.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sensor_s1_reg <= 3'h0;
      sensor_s2_reg <= 3'h0;
    end else begin
      sensor_s1_reg <= sensor_levels;
      sensor_s2_reg <= sensor_s1_reg;
    end
  end

  // The settle count lets the sensor synchroniser fill before the levels are used.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      init_cnt_reg <= 2'h0;
      init_sensor_state <= 3'h0;
      init_state_valid <= 1'b0;
    end else if (!init_state_valid) begin
      init_cnt_reg <= init_cnt_reg + 2'h1;
      if (init_cnt_reg == INIT_SETTLE) begin
        init_sensor_state <= sensor_s2_reg;
        init_state_valid <= 1'b1;
      end
    end
  end

  assign port_b_output_pins = port_b_reg;
  // The port B pins are fixed as outputs, so their enables never drop.
  assign port_b_oe = 4'hf;
  // Raw counts are brought out so a host can time edges against the PWM phase.
  assign pwm_count = pwm_tb.count;
  assign capture_count = cap_tb.count;
  assign current_loop_gain_const = LOOP_GAIN_Q3;
  // No watchdog exists here; the enable is held off so a host never arms one.
  assign watchdog_enable = 1'b0;
endmodule

// [sim/srm_gate_drv_model.sv]
// Gate driver stand-in that adds up the on time of each inverter switch.
`timescale 1ns/1ns
module srm_gate_drv_model
  import srm_pkg::*;
(
  input wire logic clk,
  input wire logic win,
  input wire logic [2*PHASES-1:0] pwm_gate,
  output int hs_cnt [PHASES],
  output int ls_cnt [PHASES]
);
  // A switch conducts while its gate input is high, so a high level is on time.
  // The totals clear while the window is closed, so each window stands alone.
  always_ff @(posedge clk) begin
    for (int p = 0; p < PHASES; p++) begin
      hs_cnt[p] <= win ? hs_cnt[p] + int'(pwm_gate[2*p]) : 0;
      ls_cnt[p] <= win ? ls_cnt[p] + int'(pwm_gate[2*p+1]) : 0;
    end
  end
endmodule

// [sim/srm_pwm_tick_scheduler_asserts.sv]
// Port-level checker for the drive timing block.
`timescale 1ns/1ns
module srm_pwm_tick_scheduler_asserts
  import srm_pkg::*;
#(
  parameter int TW = TIMER_W
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [TW-1:0] pwm_count,
  input wire logic [2:0] slice_index,
  input wire logic run_current_ctrl,
  input wire logic run_position_est,
  input wire logic run_commutation,
  input wire logic run_velocity_ctrl,
  input wire logic tick_timer_period_irq,
  input wire logic cpu_irq_group_b,
  input wire logic cpu_irq_group_c,
  input wire logic [CAP_UNITS-1:0] capture_event_irqs,
  input wire logic velocity_request,
  input wire logic [7:0] current_loop_gain_const,
  input wire logic watchdog_enable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_tick_pulse;
    run_current_ctrl && run_position_est && tick_timer_period_irq;
  endsequence
  sequence s_pulse_end;
    !run_current_ctrl && !run_commutation && !run_velocity_ctrl;
  endsequence
  a_const_outs: assert property (current_loop_gain_const == 8'h16 && !watchdog_enable)
    else $error("constant outputs wrong");
  a_grpb_tick: assert property ($rose(cpu_irq_group_b) |-> run_current_ctrl && tick_timer_period_irq)
    else $error("group b raised off a tick");
  a_grpc_src: assert property (cpu_irq_group_c |-> capture_event_irqs != 4'h0)
    else $error("group c without capture flag");
  a_pwm_wraps: assert property ($changed(pwm_count) |-> pwm_count == 0 || pwm_count == $past(pwm_count) + 1'b1)
    else $error("pwm count jumped");
  a_pwm_rate: assert property ($changed(pwm_count) |=> $stable(pwm_count) [*4])
    else $error("pwm count stepped early");
  a_slice_order: assert property ($changed(slice_index) |-> slice_index == ($past(slice_index) == 3'h4 ? 3'h0 : $past(slice_index) + 3'h1))
    else $error("slice order wrong");
  a_tick_pulse: assert property ($changed(slice_index) |-> s_tick_pulse ##1 s_pulse_end)
    else $error("tick pulses wrong");
  a_commute_slice: assert property (run_commutation |-> run_current_ctrl && slice_index == COMMUTE_SLICE)
    else $error("commutation off slice");
  a_velo_slice: assert property (run_velocity_ctrl |-> run_current_ctrl && slice_index == VELOCITY_SLICE)
    else $error("velocity off slice");
  a_cap_flags: assert property ((capture_event_irqs & ~$past(capture_event_irqs)) != 4'h0 |-> velocity_request && cpu_irq_group_c)
    else $error("capture without request");
endmodule
bind srm_pwm_tick_scheduler srm_pwm_tick_scheduler_asserts #(.TW(TW)) u_chk (.clk, .sys_rst,
  .pwm_count, .slice_index, .run_current_ctrl, .run_position_est, .run_commutation,
  .run_velocity_ctrl, .tick_timer_period_irq, .cpu_irq_group_b, .cpu_irq_group_c,
  .capture_event_irqs, .velocity_request, .current_loop_gain_const, .watchdog_enable);

// [sim/srm_pwm_tick_scheduler_tb.sv]
// Self-checking bench for the drive timing block.
`timescale 1ns/1ns
module srm_pwm_tick_scheduler_tb
  import srm_pkg::*;
;
  localparam int PER = 9;
  localparam int T = 5 * (PER + 1);
  logic clk, sys_rst, cfg_wr_en, tick_irq_clear, velocity_done, win;
  logic [2:0] cfg_sel, sensor_levels, slice_index, init_sensor_state;
  logic [15:0] cfg_wdata, pwm_count, capture_count;
  logic [3:0] capture_input_pins, capture_irq_clear, port_b_output_pins, port_b_oe;
  logic [3:0] capture_event_irqs;
  logic [5:0] pwm_gate;
  logic [63:0] capture_stamp;
  logic [1:0] last_capture_unit;
  logic [7:0] current_loop_gain_const;
  logic cpu_irq_group_b, cpu_irq_group_c, tick_timer_period_irq, velocity_request;
  logic position_new_meas, run_current_ctrl, run_position_est, run_commutation;
  logic run_velocity_ctrl, init_state_valid, watchdog_enable;
  int num_errors, cmp_count, seed, tick_gap, hs_cnt [3], ls_cnt [3];
  int sl = 4;
  time tick_t;
  srm_pwm_tick_scheduler dut (.clk, .sys_rst, .cfg_wr_en, .cfg_sel, .cfg_wdata,
    .capture_input_pins, .sensor_levels, .tick_irq_clear, .capture_irq_clear, .velocity_done,
    .pwm_gate, .port_b_output_pins, .port_b_oe, .cpu_irq_group_b, .cpu_irq_group_c,
    .tick_timer_period_irq, .capture_event_irqs, .capture_stamp, .last_capture_unit,
    .velocity_request, .position_new_meas, .slice_index, .run_current_ctrl, .run_position_est,
    .run_commutation, .run_velocity_ctrl, .init_sensor_state, .init_state_valid, .pwm_count,
    .capture_count, .current_loop_gain_const, .watchdog_enable);
  srm_gate_drv_model drv (.clk, .win, .pwm_gate, .hs_cnt, .ls_cnt);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      num_errors++;
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic cfg(input logic [2:0] s, input logic [15:0] d);
    @(posedge clk);
    cfg_wr_en <= 1'b1;
    cfg_sel <= s;
    cfg_wdata <= d;
    @(posedge clk);
    cfg_wr_en <= 1'b0;
  endtask
  task automatic wait_tick();
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (run_current_ctrl !== 1'b1 && n < 25000);
    if (n >= 25000) begin
      num_errors++;
      finish_test();
    end
    // Let the tick checker at this same edge record the gap before anyone reads it.
    #1;
  endtask
  task automatic wait_wrap();
    int n;
    n = 0;
    @(negedge clk);
    while (pwm_count === 16'h0 && n < 9) begin
      @(negedge clk);
      n++;
    end
    while (pwm_count !== 16'h0 && n < 6000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 6000) begin
      num_errors++;
      finish_test();
    end
  endtask
  // Two wraps first: a write that lands on the reload edge itself is only used one period on.
  task automatic measure(input logic mid, input logic [15:0] mid_val);
    wait_wrap();
    wait_wrap();
    @(posedge clk);
    win <= 1'b1;
    for (int i = 0; i < T; i++) begin
      @(posedge clk);
      cfg_wr_en <= mid && i == 20;
      cfg_sel <= CFG_CMP0;
      cfg_wdata <= mid_val;
    end
    win <= 1'b0;
    @(negedge clk);
  endtask
  // Every tick is checked against a slice count kept from reset onwards.
  always @(negedge clk) begin
    if (run_current_ctrl === 1'b1) begin
      sl = (sl + 1) % 5;
      tick_gap = 32'(($time - tick_t) / 10);
      tick_t = $time;
      chk(slice_index, sl);
      chk(run_commutation, sl == 0);
      chk(run_velocity_ctrl, sl == 1);
      chk(run_position_est, 1);
      chk(cpu_irq_group_b, 1);
    end
  end
  initial begin
    #600_000;
    num_errors++;
    finish_test();
  end
  initial begin
    int cv [5], ex [4], e, u;
    logic en;
    logic [15:0] d;
    time t0;
    seed = 25444;
    {sys_rst, cfg_wr_en, cfg_sel, cfg_wdata, win} = {1'b1, 20'h0, 1'b0};
    {capture_input_pins, tick_irq_clear, capture_irq_clear, velocity_done} = 10'h0;
    sensor_levels = 3'($random(seed));
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    chk(init_state_valid, 1);
    chk(init_sensor_state, sensor_levels);
    chk(current_loop_gain_const, 8'h16);
    chk(watchdog_enable, 0);
    d = 16'($random(seed));
    cfg(CFG_PORT_B, d);
    @(negedge clk);
    chk(port_b_output_pins, d[3:0]);
    chk(port_b_oe, 4'hf);
    wait_wrap();
    t0 = $time;
    wait_wrap();
    chk(32'(($time - t0) / 10), 5000);
    wait_tick();
    wait_tick();
    chk(tick_gap, 20000);
    cfg(CFG_TICK_PERIOD, 16'(PER));
    wait_tick();
    wait_tick();
    chk(tick_gap, T);
    @(posedge clk);
    tick_irq_clear <= 1'b1;
    @(posedge clk);
    tick_irq_clear <= 1'b0;
    @(negedge clk);
    chk(cpu_irq_group_b, 0);
    cfg(CFG_PWM_PERIOD, 16'(PER));
    cv = '{0, 1, PER, PER + 3, int'($random(seed) & 7)};
    foreach (cv[k]) begin
      for (int p = 0; p < 3; p++) cfg(CFG_CMP0 + 3'(p), 16'(cv[k]));
      measure(1'b0, 16'h0);
      e = cv[k] >= PER ? T : 5 * cv[k];
      for (int p = 0; p < 3; p++) chk(hs_cnt[p], e);
      chk(ls_cnt[0] + ls_cnt[1] + ls_cnt[2], 0);
    end
    for (int p = 0; p < 3; p++) cfg(CFG_CMP0 + 3'(p), 16'h3);
    ex = '{0, T - 15, 15, T};
    for (int a = 0; a < 4; a++) begin
      cfg(CFG_ACTION, {4'h0, 8'h22, 2'(3 - a), 2'(a)});
      measure(1'b0, 16'h0);
      chk(hs_cnt[0], ex[a]);
      chk(ls_cnt[0], ex[3 - a]);
    end
    cfg(CFG_ACTION, 16'(ACTION_RST));
    cfg(CFG_CMP0, 16'h2);
    measure(1'b1, 16'h7);
    chk(hs_cnt[0], 10);
    measure(1'b0, 16'h0);
    chk(hs_cnt[0], 35);
    for (int i = 0; i < 2; i++) begin
      d = capture_count;
      t0 = $time;
      while (capture_count === d && $time - t0 < 2000) @(negedge clk);
    end
    chk(32'(($time - t0) / 10), 80);
    for (int k = 0; k < 8; k++) begin
      u = k / 2;
      en = u < 3 || k == 7;
      wait_tick();
      if (k == 7) cfg(CFG_CAP_EN, 16'hf);
      @(posedge clk);
      capture_input_pins[u] <= ~capture_input_pins[u];
      repeat (6) @(posedge clk);
      @(negedge clk);
      chk(capture_event_irqs, 32'(en) << u);
      chk(cpu_irq_group_c, en);
      chk(velocity_request, en);
      if (en) chk(last_capture_unit, u);
      if (en) chk((capture_count - capture_stamp[16*u +: 16]) < 2, 1);
      wait_tick();
      chk(position_new_meas, en);
      @(posedge clk);
      capture_irq_clear <= 4'hf;
      velocity_done <= 1'b1;
      @(posedge clk);
      capture_irq_clear <= 4'h0;
      velocity_done <= 1'b0;
      @(negedge clk);
      chk(capture_event_irqs, 0);
      chk(velocity_request, 0);
    end
    finish_test();
  end
endmodule
